// file: vish_pkg.sv
// Package for the vector integer shift and compare datapath
package vish_pkg;

	localparam int ELEN_MAX      = 64;
	localparam int IMM_W         = 5;
	localparam int CMP_IMM_MIN   = -16;
	localparam int CMP_IMM_MAX   = 15;
	localparam int LATENCY       = 1;

	typedef enum logic [3:0] {
		VISH_OP_SLL  = 4'h0,
		VISH_OP_SRL  = 4'h1,
		VISH_OP_SRA  = 4'h2,
		VISH_OP_NSRL = 4'h3,
		VISH_OP_NSRA = 4'h4,
		VISH_OP_XOR  = 4'h5,
		VISH_OP_SEQ  = 4'h6,
		VISH_OP_SNE  = 4'h7,
		VISH_OP_SLTU = 4'h8,
		VISH_OP_SLT  = 4'h9,
		VISH_OP_SLEU = 4'ha,
		VISH_OP_SLE  = 4'hb,
		VISH_OP_SGTU = 4'hc,
		VISH_OP_SGT  = 4'hd
	} vish_op_e;

	typedef enum logic [1:0] {
		VISH_SRC_VEC = 2'h0,
		VISH_SRC_SCL = 2'h1,
		VISH_SRC_IMM = 2'h2
	} vish_src_e;

	typedef enum logic [1:0] {
		VISH_EW_8  = 2'h0,
		VISH_EW_16 = 2'h1,
		VISH_EW_32 = 2'h2,
		VISH_EW_64 = 2'h3
	} vish_ew_e;

	typedef struct packed {
		vish_op_e  op;
		vish_src_e src;
		vish_ew_e  element_width;
		logic      mask_enable_bit;
		logic      mask_undisturbed;
		logic      dest_is_mask_source;
	} vish_ctl_s;

endpackage

// file: vish_lane.sv
// One element lane: shifts, xor and compares, combinational
`timescale 1ns/1ps
module vish_lane #(
	parameter int W = 64
) (
	input  wire logic              [3:0]   op,
	input  wire logic              [1:0]   ew,
	input  wire logic              [2*W-1:0] wide_src,
	input  wire logic              [W-1:0] opnd_b,
	output logic                   [W-1:0] elem_res,
	output logic                           cmp_res,
	output logic                           illegal
);

	function automatic int ew_bits(input logic [1:0] e);
		return 8 << e;
	endfunction

	function automatic logic [W-1:0] sext_top(input logic [W-1:0] v, input int n);
		logic [W-1:0] r;
		r = v;
		for (int k = 0; k < W; k++) begin
			if (k >= n)
				r[k] = v[n-1];
		end
		return r;
	endfunction

	function automatic logic [W-1:0] zext_top(input logic [W-1:0] v, input int n);
		logic [W-1:0] r;
		r = v;
		for (int k = 0; k < W; k++) begin
			if (k >= n)
				r[k] = 1'b0;
		end
		return r;
	endfunction

	int                     n;
	logic [6:0]             amt;
	logic [W-1:0]           a_s, b_s, a_u, b_u;
	logic [2*W-1:0]         wide_u, wide_s, wide_sh;

	always_comb begin
		n        = ew_bits(ew);
		a_u      = zext_top(wide_src[W-1:0], n);
		b_u      = zext_top(opnd_b, n);
		a_s      = sext_top(wide_src[W-1:0], n);
		b_s      = sext_top(opnd_b, n);
		elem_res = '0;
		cmp_res  = 1'b0;
		illegal  = 1'b0;
		amt      = '0;
		wide_sh  = '0;
		wide_u   = '0;
		wide_s   = '0;
		unique case (vish_pkg::vish_op_e'(op))
			vish_pkg::VISH_OP_SLL: begin
				amt      = 7'(opnd_b & 64'(n - 1));
				elem_res = zext_top(a_u << amt, n);
			end
			vish_pkg::VISH_OP_SRL: begin
				amt      = 7'(opnd_b & 64'(n - 1));
				elem_res = a_u >> amt;
			end
			vish_pkg::VISH_OP_SRA: begin
				amt      = 7'(opnd_b & 64'(n - 1));
				elem_res = zext_top(W'($signed(a_s) >>> amt), n);
			end
			vish_pkg::VISH_OP_NSRL, vish_pkg::VISH_OP_NSRA: begin
				// Double-width source; 64-bit elements cannot narrow further
				illegal = (ew == 2'h3);
				amt     = 7'(opnd_b & 64'(2 * n - 1));
				for (int k = 0; k < 2 * W; k++) begin
					wide_u[k] = (k < 2 * n) ? wide_src[k] : 1'b0;
					wide_s[k] = (k < 2 * n) ? wide_src[k] : wide_src[2 * n - 1];
				end
				if (op == 4'(vish_pkg::VISH_OP_NSRA))
					wide_sh = (2*W)'($signed(wide_s) >>> amt);
				else
					wide_sh = wide_u >> amt;
				elem_res = zext_top(wide_sh[W-1:0], n);
			end
			vish_pkg::VISH_OP_XOR: elem_res = zext_top(a_u ^ b_u, n);
			vish_pkg::VISH_OP_SEQ:  cmp_res = (a_u == b_u);
			vish_pkg::VISH_OP_SNE:  cmp_res = (a_u != b_u);
			vish_pkg::VISH_OP_SLTU: cmp_res = (a_u < b_u);
			vish_pkg::VISH_OP_SLT:  cmp_res = ($signed(a_s) < $signed(b_s));
			vish_pkg::VISH_OP_SLEU: cmp_res = (a_u <= b_u);
			vish_pkg::VISH_OP_SLE:  cmp_res = ($signed(a_s) <= $signed(b_s));
			vish_pkg::VISH_OP_SGTU: cmp_res = (a_u > b_u);
			vish_pkg::VISH_OP_SGT:  cmp_res = ($signed(a_s) > $signed(b_s));
			default: illegal = 1'b1;
		endcase
	end

endmodule

// file: vish_top.sv
// Vector integer shift, narrowing shift, xor and compare datapath
`timescale 1ns/1ps
module vish_top #(
	parameter int NLANE = 4,
	parameter int W     = vish_pkg::ELEN_MAX
) (
	input  wire logic                     MCLK,
	input  wire logic                     RST_N,
	input  wire logic                     IN_VALID,
	input  wire vish_pkg::vish_ctl_s      IN_CTL,
	input  wire logic [NLANE*2*W-1:0]     IN_FIRST_VECTOR_SOURCE,
	input  wire logic [NLANE*W-1:0]       IN_SECOND_VECTOR_SOURCE,
	input  wire logic [W-1:0]             IN_SCALAR_SOURCE,
	input  wire logic [vish_pkg::IMM_W-1:0] IN_IMM,
	input  wire logic [NLANE-1:0]         IN_MASK_SOURCE_REGISTER,
	input  wire logic [NLANE-1:0]         IN_BODY,
	input  wire logic [NLANE-1:0]         IN_OLD_MASK,
	input  wire logic [NLANE*W-1:0]       IN_OLD_DEST,
	output logic                          OUT_VALID,
	output logic [NLANE*W-1:0]            OUT_VECTOR_DESTINATION,
	output logic [NLANE-1:0]              OUT_MASK_DEST,
	output logic [NLANE-1:0]              OUT_ELEM_WE,
	output logic                          OUT_IS_MASK,
	output logic                          OUT_ILLEGAL
);

	typedef struct packed {
		logic                 valid;
		logic [NLANE*W-1:0]   data;
		logic [NLANE-1:0]     mask;
		logic [NLANE-1:0]     we;
		logic                 is_mask;
		logic                 illegal;
	} vish_state_s;

	function automatic logic is_cmp(input logic [3:0] o);
		return o >= 4'(vish_pkg::VISH_OP_SEQ);
	endfunction

	function automatic logic is_shift(input logic [3:0] o);
		return o <= 4'(vish_pkg::VISH_OP_NSRA);
	endfunction

	vish_state_s       st_q, st_d;
	logic [W-1:0]      opnd_b    [NLANE];
	logic [W-1:0]      lane_res  [NLANE];
	logic [NLANE-1:0]  lane_cmp;
	logic [NLANE-1:0]  lane_ill;
	logic [W-1:0]      imm_ext;
	logic              form_bad;
	logic [3:0]        op;

	assign op = IN_CTL.op;

	always_comb begin
		// Shifts zero-extend the immediate, everything else sign-extends
		if (is_shift(op))
			imm_ext = W'(IN_IMM);
		else
			imm_ext = W'($signed(IN_IMM));
	end

	// Encodings with no such form are flagged instead of executed
	always_comb begin
		form_bad = 1'b0;
		if (op == 4'(vish_pkg::VISH_OP_SGT) || op == 4'(vish_pkg::VISH_OP_SGTU))
			form_bad = (IN_CTL.src == vish_pkg::VISH_SRC_VEC);
		if (op == 4'(vish_pkg::VISH_OP_SLT) || op == 4'(vish_pkg::VISH_OP_SLTU))
			form_bad = (IN_CTL.src == vish_pkg::VISH_SRC_IMM);
		if (IN_CTL.src == 2'h3)
			form_bad = 1'b1;
	end

	for (genvar i = 0; i < NLANE; i++) begin : g_lane
		always_comb begin
			unique case (IN_CTL.src)
				vish_pkg::VISH_SRC_VEC: opnd_b[i] = IN_SECOND_VECTOR_SOURCE[i*W +: W];
				vish_pkg::VISH_SRC_SCL: opnd_b[i] = IN_SCALAR_SOURCE;
				default:                opnd_b[i] = imm_ext;
			endcase
		end

		vish_lane #(
			.W (W)
		) u_lane (
			.op       (op),
			.ew       (IN_CTL.element_width),
			.wide_src (IN_FIRST_VECTOR_SOURCE[i*2*W +: 2*W]),
			.opnd_b   (opnd_b[i]),
			.elem_res (lane_res[i]),
			.cmp_res  (lane_cmp[i]),
			.illegal  (lane_ill[i])
		);
	end

	always_comb begin
		logic [NLANE-1:0] active;
		active = IN_BODY & (IN_CTL.mask_enable_bit ? {NLANE{1'b1}} : IN_MASK_SOURCE_REGISTER);
		st_d         = st_q;
		st_d.valid   = IN_VALID;
		st_d.is_mask = is_cmp(op);
		st_d.illegal = IN_VALID & (form_bad | (|lane_ill));
		st_d.we      = '0;
		for (int i = 0; i < NLANE; i++) begin
			// Inactive and tail data elements keep their old value; compare mask bits may be set to ones below
			st_d.data[i*W +: W] = IN_OLD_DEST[i*W +: W];
			st_d.mask[i]        = IN_OLD_MASK[i];
			if (active[i]) begin
				st_d.data[i*W +: W] = lane_res[i];
				st_d.mask[i]        = lane_cmp[i];
			end else if (is_cmp(op) && !IN_BODY[i]) begin
				// Agnostic tail: write ones rather than tracking old bits
				st_d.mask[i] = 1'b1;
			end else if (is_cmp(op) && !IN_CTL.mask_undisturbed) begin
				st_d.mask[i] = 1'b1;
			end else if (is_cmp(op) && IN_CTL.dest_is_mask_source) begin
				// Old mask bit is zero here, so result equals new AND old
				st_d.mask[i] = IN_MASK_SOURCE_REGISTER[i];
			end
			st_d.we[i] = IN_VALID & active[i] & ~is_cmp(op);
		end
		if (!IN_VALID || st_d.illegal) begin
			st_d.we      = '0;
			st_d.is_mask = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign OUT_VALID              = st_q.valid;
	assign OUT_VECTOR_DESTINATION = st_q.data;
	assign OUT_MASK_DEST          = st_q.mask;
	assign OUT_ELEM_WE            = st_q.we;
	assign OUT_IS_MASK            = st_q.is_mask;
	assign OUT_ILLEGAL            = st_q.illegal;

	property p_valid_lat;
		@(posedge MCLK) disable iff (!RST_N) IN_VALID |=> OUT_VALID;
	endproperty
	a_valid_lat: assert property (p_valid_lat) else $error("valid not echoed");

	property p_gt_vec;
		@(posedge MCLK) disable iff (!RST_N)
		(IN_VALID && op == 4'(vish_pkg::VISH_OP_SGT) && IN_CTL.src == vish_pkg::VISH_SRC_VEC)
		|=> OUT_ILLEGAL;
	endproperty
	a_gt_vec: assert property (p_gt_vec) else $error("gt vector form accepted");

	property p_lt_imm;
		@(posedge MCLK) disable iff (!RST_N)
		(IN_VALID && (op == 4'(vish_pkg::VISH_OP_SLTU) || op == 4'(vish_pkg::VISH_OP_SLT))
			&& IN_CTL.src == vish_pkg::VISH_SRC_IMM)
		|=> OUT_ILLEGAL && OUT_ELEM_WE == '0;
	endproperty
	a_lt_imm: assert property (p_lt_imm) else $error("lt immediate form accepted");

	property p_inactive_keep;
		@(posedge MCLK) disable iff (!RST_N)
		(IN_VALID && !IN_CTL.mask_enable_bit && !IN_MASK_SOURCE_REGISTER[0] && !is_cmp(op))
		|=> !OUT_ELEM_WE[0] && OUT_VECTOR_DESTINATION[W-1:0] == $past(IN_OLD_DEST[W-1:0]);
	endproperty
	a_inactive_keep: assert property (p_inactive_keep) else $error("inactive lane written");

	property p_cmp_no_we;
		@(posedge MCLK) disable iff (!RST_N) (IN_VALID && is_cmp(op)) |=> OUT_ELEM_WE == '0;
	endproperty
	a_cmp_no_we: assert property (p_cmp_no_we) else $error("compare wrote elements");

	property p_and_mask;
		@(posedge MCLK) disable iff (!RST_N)
		(IN_VALID && is_cmp(op) && IN_CTL.mask_undisturbed && IN_CTL.dest_is_mask_source
			&& !IN_CTL.mask_enable_bit && !form_bad)
		|=> (OUT_MASK_DEST & ~$past(IN_MASK_SOURCE_REGISTER) & $past(IN_BODY)) == '0;
	endproperty
	a_and_mask: assert property (p_and_mask) else $error("mask not ANDed");

	property p_tail_one;
		@(posedge MCLK) disable iff (!RST_N)
		(IN_VALID && is_cmp(op) && !IN_BODY[NLANE-1] && !form_bad) |=> OUT_MASK_DEST[NLANE-1];
	endproperty
	a_tail_one: assert property (p_tail_one) else $error("tail mask bit not ones");

	property p_xor_not;
		@(posedge MCLK) disable iff (!RST_N)
		(IN_VALID && op == 4'(vish_pkg::VISH_OP_XOR) && IN_CTL.src == vish_pkg::VISH_SRC_IMM
			&& IN_IMM == 5'h1f && IN_CTL.element_width == vish_pkg::VISH_EW_64 && IN_BODY[0]
			&& IN_CTL.mask_enable_bit)
		|=> OUT_VECTOR_DESTINATION[W-1:0] == ~$past(IN_FIRST_VECTOR_SOURCE[W-1:0]);
	endproperty
	a_xor_not: assert property (p_xor_not) else $error("xor -1 not inverting");

	property p_sll_amt;
		@(posedge MCLK) disable iff (!RST_N)
		(IN_VALID && op == 4'(vish_pkg::VISH_OP_SLL) && IN_CTL.src == vish_pkg::VISH_SRC_SCL
			&& IN_CTL.element_width == vish_pkg::VISH_EW_8 && IN_BODY[0]
			&& IN_CTL.mask_enable_bit && IN_SCALAR_SOURCE == 64'h9)
		|=> OUT_VECTOR_DESTINATION[7:0] == 8'($past(IN_FIRST_VECTOR_SOURCE[7:0]) << 1);
	endproperty
	a_sll_amt: assert property (p_sll_amt) else $error("shift amount not truncated");

endmodule

// file: vish_issue.sv
// Issue-side model: presents one operation per call to the datapath
`timescale 1ns/1ps
module vish_issue (
	input  wire logic           clk,
	output logic                valid,
	output vish_pkg::vish_ctl_s ctl,
	output logic [511:0]        src_a,
	output logic [255:0]        src_b,
	output logic [63:0]         scalar,
	output logic [4:0]          imm,
	output logic [3:0]          msk,
	output logic [3:0]          body,
	output logic [3:0]          old_mask,
	output logic [255:0]        old_dest
);
	initial begin
		valid = 1'b0;
		ctl = '0;
		{src_a, src_b, scalar, imm} = '0;
		{msk, body, old_mask, old_dest} = '0;
	end
	// Held from just after one edge until the edge that takes them
	task automatic send(input vish_pkg::vish_ctl_s c, input logic [511:0] a,
		input logic [255:0] b, input logic [63:0] s, input logic [4:0] i,
		input logic [11:0] mbo, input logic [255:0] od);
		@(posedge clk);
		#1;
		valid = 1'b1;
		ctl = c;
		{src_a, src_b, scalar, imm} = {a, b, s, i};
		{msk, body, old_mask} = mbo;
		old_dest = od;
		@(posedge clk);
		#1;
		valid = 1'b0;
		// Inverted on release so a stale operand cannot pass for a live one
		{src_a, src_b, scalar} = ~{src_a, src_b, scalar};
	endtask
endmodule

// file: vish_top_tb.sv
// Self-checking bench for the shift, xor and compare datapath
`timescale 1ns/1ps
module vish_top_tb;
	logic                MCLK;
	logic                RST_N;
	logic                v;
	vish_pkg::vish_ctl_s c;
	logic [511:0]        a;
	logic [255:0]        b;
	logic [255:0]        od;
	logic [63:0]         s;
	logic [4:0]          i;
	logic [3:0]          m;
	logic [3:0]          bd;
	logic [3:0]          om;
	logic                o_valid;
	logic [255:0]        o_dest;
	logic [3:0]          o_mask;
	logic [3:0]          o_we;
	logic                o_is_mask;
	logic                o_ill;
	int                  errors = 0;
	int                  tests_run = 0;

	vish_issue P (.clk(MCLK), .valid(v), .ctl(c), .src_a(a), .src_b(b), .scalar(s), .imm(i),
		.msk(m), .body(bd), .old_mask(om), .old_dest(od));
	vish_top #(.NLANE(4), .W(64)) DUT (.MCLK(MCLK), .RST_N(RST_N), .IN_VALID(v), .IN_CTL(c),
		.IN_FIRST_VECTOR_SOURCE(a), .IN_SECOND_VECTOR_SOURCE(b), .IN_SCALAR_SOURCE(s),
		.IN_IMM(i), .IN_MASK_SOURCE_REGISTER(m), .IN_BODY(bd), .IN_OLD_MASK(om),
		.IN_OLD_DEST(od), .OUT_VALID(o_valid), .OUT_VECTOR_DESTINATION(o_dest),
		.OUT_MASK_DEST(o_mask), .OUT_ELEM_WE(o_we), .OUT_IS_MASK(o_is_mask),
		.OUT_ILLEGAL(o_ill));

	task automatic chk(input logic [255:0] g, input logic [255:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic vish_pkg::vish_ctl_s cf(input logic [3:0] op, input logic [1:0] sr,
		input logic [1:0] ew, input logic [2:0] f);
		return {op, sr, ew, f};
	endfunction
	// Flags f are mask_enable_bit, undisturbed, destination is mask source
	task automatic run(input vish_pkg::vish_ctl_s cc, input logic [511:0] aa,
		input logic [255:0] bb, input logic [63:0] ss, input logic [4:0] ii,
		input logic [11:0] mbo, input logic [255:0] dd);
		P.send(cc, aa, bb, ss, ii, mbo, dd);
		chk(o_valid, 1'b1);
	endtask

	task automatic t_shift();
		logic [255:0] amt;
		logic [255:0] ex [3];
		amt = {64'h0, 64'h7, 64'h9, 64'h1};
		ex[0] = {64'h81, 64'h80, 64'h2, 64'h2};
		ex[1] = {64'h81, 64'h1, 64'h40, 64'h40};
		ex[2] = {64'h81, 64'hff, 64'hc0, 64'hc0};
		for (int k = 0; k < 3; k++) begin
			run(cf(4'(k), 2'h0, 2'h0, 3'h4), {4{128'h81}}, amt, 64'h0, 5'h0, 12'h0f0, 256'h0);
			chk(o_dest, ex[k]);
			chk(o_we, 4'hf);
		end
		run(cf(4'h1, 2'h1, 2'h3, 3'h4), {4{128'h8000000000000000}}, 256'h0, 64'h41, 5'h0,
			12'h0f0, 256'h0);
		chk(o_dest, {4{64'h4000000000000000}});
		run(cf(4'h1, 2'h2, 2'h3, 3'h4), {4{128'h8000000000000000}}, 256'h0, 64'h0, 5'h1f,
			12'h0f0, 256'h0);
		chk(o_dest, {4{64'h100000000}});
		run(cf(4'h0, 2'h1, 2'h0, 3'h4), {4{128'h81}}, 256'h0, 64'h9, 5'h0, 12'h0f0, 256'h0);
		chk(o_dest, {4{64'h2}});
		// Lanes 0 and 2 masked off, lane 3 in the tail: all keep the old element
		run(cf(4'h0, 2'h0, 2'h0, 3'h2), {4{128'h81}}, amt, 64'h0, 5'h0, 12'ha70, {4{64'h5a}});
		chk(o_dest, {64'h5a, 64'h5a, 64'h2, 64'h5a});
		chk(o_we, 4'h2);
	endtask

	task automatic t_narrow();
		logic [255:0] ex [2];
		ex[0] = {64'h0, 64'h1, 64'h40000000, 64'h40000000};
		ex[1] = {64'h0, 64'hffffffff, 64'hc0000000, 64'hc0000000};
		for (int k = 0; k < 2; k++) begin
			run(cf(4'(k + 3), 2'h0, 2'h2, 3'h4), {4{128'h8000000000000000}},
				{64'h0, 64'h3f, 64'h61, 64'h21}, 64'h0, 5'h0, 12'h0f0, 256'h0);
			chk(o_dest, ex[k]);
		end
		run(cf(4'h3, 2'h2, 2'h0, 3'h4), {4{128'h8000}}, 256'h0, 64'h0, 5'h1f, 12'h0f0, 256'h0);
		chk(o_dest, {4{64'h1}});
		run(cf(4'h4, 2'h1, 2'h0, 3'h4), {4{128'h8000}}, 256'h0, 64'h4f, 5'h0, 12'h0f0, 256'h0);
		chk(o_dest, {4{64'hff}});
		run(cf(4'h3, 2'h0, 2'h3, 3'h4), {4{128'h8000}}, 256'h0, 64'h0, 5'h0, 12'h0f0, 256'h0);
		chk({o_ill, o_we}, 5'h10);
		run(cf(4'h5, 2'h2, 2'h1, 3'h4), {4{128'h1234}}, 256'h0, 64'h0, 5'h1f, 12'h0f0, 256'h0);
		chk(o_dest, {4{64'hedcb}});
		run(cf(4'h5, 2'h2, 2'h3, 3'h4), {4{128'h1234}}, 256'h0, 64'h0, 5'h1f, 12'h0f0, 256'h0);
		chk(o_dest, {4{64'hffffffffffffedcb}});
	endtask

	task automatic t_cmp();
		logic [511:0] va;
		logic [15:0]  srcs;
		logic [31:0]  ex;
		va = {128'h10, 128'h0, 128'hfb, 128'h5};
		srcs = 16'h6244;
		ex = 32'hd02f0dd2;
		for (int k = 0; k < 8; k++) begin
			run(cf(4'(k + 6), srcs[2*k+:2], 2'h0, 3'h4), va, {4{64'hfb}}, 64'hfb, 5'h1b,
				12'h0f0, 256'h0);
			chk(o_mask, ex[4*k+:4]);
			chk({o_is_mask, o_we, o_ill}, 6'h20);
		end
		run(cf(4'hd, 2'h0, 2'h0, 3'h4), va, 256'h0, 64'h0, 5'h0, 12'h0f0, 256'h0);
		chk({o_is_mask, o_ill}, 2'h1);
		run(cf(4'h9, 2'h2, 2'h0, 3'h4), va, 256'h0, 64'h0, 5'h0, 12'h0f0, 256'h0);
		chk({o_is_mask, o_ill}, 2'h1);
		// Greater-or-equal made from greater-than with the scalar lowered by one
		run(cf(4'hc, 2'h1, 2'h0, 3'h4), va, 256'h0, 64'h4, 5'h0, 12'h0f0, 256'h0);
		chk(o_mask, 4'hb);
		run(cf(4'h6, 2'h0, 2'h0, 3'h3), va, {4{64'hfb}}, 64'h0, 5'h0, 12'h671, 256'h0);
		chk(o_mask, 4'ha);
		run(cf(4'h6, 2'h0, 2'h0, 3'h2), va, {4{64'hfb}}, 64'h0, 5'h0, 12'h671, 256'h0);
		chk(o_mask, 4'hb);
		run(cf(4'h6, 2'h0, 2'h0, 3'h0), va, {4{64'hfb}}, 64'h0, 5'h0, 12'h670, 256'h0);
		chk(o_mask, 4'hb);
	endtask

	task automatic stop_test();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end
	// About thirty operations of two cycles each; this span is far beyond them
	initial begin
		#20000;
		errors++;
		stop_test();
	end
	initial begin
		RST_N = 1'b0;
		repeat (6) @(posedge MCLK);
		#1;
		RST_N = 1'b1;
		chk(o_valid, 1'b0);
		chk(o_dest, 256'h0);
		chk(o_we, 4'h0);
		t_shift();
		t_narrow();
		t_cmp();
		stop_test();
	end
endmodule
